// ===== dpwmc_core.sv
// Register file, chopping timers and gate decode for both H-bridges.
// Assumes all pin and millivolt inputs are synchronous to core_clk.
`timescale 1ns/1ps
module dpwmc_core #(
    parameter int OffStepCycles = dpwmc_pkg::OFF_TIME_FIELD_STEP_CYCLES
) (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic rst_b,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [dpwmc_pkg::APB_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Bridge input pins and indexer commands.
    input wire logic bridgeAInputOne,
    input wire logic bridgeAInputTwo,
    input wire logic bridgeBInputOne,
    input wire logic bridgeBInputTwo,
    input wire logic [1:0] indexerCmdA,
    input wire logic [1:0] indexerCmdB,
    input wire logic sleepLowInput_b,
    // Measured sense and transistor drop voltages.
    input wire logic [dpwmc_pkg::SENSE_W-1:0] senseMvA,
    input wire logic [dpwmc_pkg::SENSE_W-1:0] senseMvB,
    input wire logic [dpwmc_pkg::DROP_W-1:0] fetDropMvA,
    input wire logic [dpwmc_pkg::DROP_W-1:0] fetDropMvB,
    // Gate drive.
    output dpwmc_pkg::dpwmc_gate_t gateA,
    output dpwmc_pkg::dpwmc_gate_t gateB
);
    import dpwmc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [5:0] senseGain(input logic [1:0] sel);
        unique case (sel)
            2'h0: return GAIN_X5;
            2'h1: return GAIN_X10;
            2'h2: return GAIN_X20;
            2'h3: return GAIN_X40;
        endcase
    endfunction

    function automatic logic [DROP_W-1:0] ocpLevel(input logic [1:0] sel);
        unique case (sel)
            2'h0: return OCP_MV_250;
            2'h1: return OCP_MV_500;
            2'h2: return OCP_MV_750;
            2'h3: return OCP_MV_1000;
        endcase
    endfunction

    // The reference is a fixed constant here; an external trim would change the whole scale.
    function automatic logic chopTrip(input logic [SENSE_W-1:0] mv, input logic [1:0] gsel,
                                      input logic [7:0] torque);
        logic [CMP_W-1:0] lhs;
        logic [CMP_W-1:0] rhs;
        lhs = (CMP_W'(mv) * CMP_W'(senseGain(gsel))) << TORQUE_SHIFT;
        rhs = CMP_W'(VREF_FULL_MV) * CMP_W'(torque);
        return lhs >= rhs;
    endfunction

    function automatic logic [OFF_CNT_W-1:0] offTotal(input logic [7:0] field);
        return OFF_CNT_W'((OFF_CNT_W'(field) + OFF_CNT_W'(1)) * OFF_CNT_W'(OffStepCycles));
    endfunction

    function automatic logic isDriving(input logic [1:0] cmd);
        return (cmd == CMD_FWD) || (cmd == CMD_REV);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Registers.
    logic enable_r, enable_nxt;
    logic [1:0] gainSel_r, gainSel_nxt;
    logic [1:0] ocpSel_r, ocpSel_nxt;
    logic [7:0] offTime_r, offTime_nxt;
    logic directSel_r, directSel_nxt;
    logic [7:0] torque_r, torque_nxt;
    dpwmc_decay_t decay_r, decay_nxt;
    logic [1:0] ocpFlag_r, ocpFlag_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic wrEn, mapped;
    logic [31:0] rdVal;
    logic [1:0] ocpEvent;
    dpwmc_chop_t chopState_r [2];
    dpwmc_chop_t chopState_nxt [2];

    assign wrEn = psel && penable && pwrite;
    assign pready = 1'b1;
    assign prdata = prdata_r;
    assign mapped = (paddr == CTRL_OFFS) || (paddr == OFFT_OFFS) || (paddr == TORQ_OFFS) ||
                    (paddr == DECAY_OFFS) || (paddr == STAT_OFFS);
    assign pslverr = psel && penable && !mapped;

    always_comb
    begin
        rdVal = 32'h0;
        unique case (paddr)
            CTRL_OFFS: rdVal = 32'({ocpSel_r, gainSel_r, enable_r});
            OFFT_OFFS: rdVal = 32'({directSel_r, offTime_r});
            TORQ_OFFS: rdVal = 32'(torque_r);
            DECAY_OFFS: rdVal = 32'(decay_r);
            STAT_OFFS: rdVal = 32'({directSel_r, chopState_r[1] == CHOP_OFF,
                                    chopState_r[0] == CHOP_OFF, ocpFlag_r});
            default: rdVal = 32'h0;
        endcase
    end

    always_comb
    begin
        enable_nxt = enable_r;
        gainSel_nxt = gainSel_r;
        ocpSel_nxt = ocpSel_r;
        offTime_nxt = offTime_r;
        directSel_nxt = directSel_r;
        torque_nxt = torque_r;
        decay_nxt = decay_r;
        ocpFlag_nxt = ocpFlag_r;
        prdata_nxt = prdata_r;
        if (psel && !penable && !pwrite)
        begin
            prdata_nxt = rdVal;
        end
        if (wrEn)
        begin
            unique case (paddr)
                CTRL_OFFS:
                begin
                    enable_nxt = pwdata[CTRL_EN_BIT];
                    gainSel_nxt = pwdata[CTRL_GAIN_LSB +: 2];
                    ocpSel_nxt = pwdata[CTRL_OCP_LSB +: 2];
                end
                OFFT_OFFS:
                begin
                    offTime_nxt = pwdata[OFFT_TIME_LSB +: 8];
                    directSel_nxt = pwdata[OFFT_DIRECT_BIT];
                end
                TORQ_OFFS: torque_nxt = pwdata[7:0];
                DECAY_OFFS: decay_nxt = dpwmc_decay_t'(pwdata[1:0]);
                STAT_OFFS: ocpFlag_nxt = ocpFlag_r & ~pwdata[STAT_OCP_LSB +: 2];
                default: ;
            endcase
        end
        // A fault in the clearing cycle stays flagged.
        ocpFlag_nxt = ocpFlag_nxt | ocpEvent;
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            enable_r <= 1'b0;
            gainSel_r <= GAIN_RST;
            ocpSel_r <= OCP_RST;
            offTime_r <= OFFT_RST;
            directSel_r <= 1'b0;
            torque_r <= TORQ_RST;
            decay_r <= DECAY_SLOW;
            ocpFlag_r <= 2'h0;
            prdata_r <= 32'h0;
        end
        else
        begin
            enable_r <= enable_nxt;
            gainSel_r <= gainSel_nxt;
            ocpSel_r <= ocpSel_nxt;
            offTime_r <= offTime_nxt;
            directSel_r <= directSel_nxt;
            torque_r <= torque_nxt;
            decay_r <= decay_nxt;
            ocpFlag_r <= ocpFlag_nxt;
            prdata_r <= prdata_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Chopping and gate decode, one lane per bridge.
    logic [1:0] cmd [2];
    logic [1:0] trip;
    logic [SENSE_W-1:0] senseMv [2];
    logic [DROP_W-1:0] fetDropMv [2];
    logic [OFF_CNT_W-1:0] offCnt_r [2];
    logic [OFF_CNT_W-1:0] offCnt_nxt [2];
    dpwmc_gate_t gate_r [2];
    dpwmc_gate_t gate_nxt [2];
    logic [OFF_CNT_W-1:0] offLen;
    logic run;

    assign cmd[0] = directSel_r ? {bridgeAInputOne, bridgeAInputTwo} : indexerCmdA;
    assign cmd[1] = directSel_r ? {bridgeBInputOne, bridgeBInputTwo} : indexerCmdB;
    assign senseMv[0] = senseMvA;
    assign senseMv[1] = senseMvB;
    assign fetDropMv[0] = fetDropMvA;
    assign fetDropMv[1] = fetDropMvB;
    assign offLen = offTotal(offTime_r);
    assign run = enable_r && sleepLowInput_b;
    assign gateA = gate_r[0];
    assign gateB = gate_r[1];

    always_comb
    begin
        for (int b = 0; b < 2; b++)
        begin
            trip[b] = chopTrip(senseMv[b], gainSel_r, torque_r);
            ocpEvent[b] = run && isDriving(cmd[b]) && (fetDropMv[b] >= ocpLevel(ocpSel_r));
            chopState_nxt[b] = chopState_r[b];
            offCnt_nxt[b] = offCnt_r[b];
            gate_nxt[b] = GATE_OFF;
            unique case (chopState_r[b])
                CHOP_DRIVE:
                begin
                    if (run && isDriving(cmd[b]) && trip[b])
                    begin
                        chopState_nxt[b] = CHOP_OFF;
                        offCnt_nxt[b] = offLen - OFF_CNT_W'(1);
                    end
                end
                CHOP_OFF:
                begin
                    if (offCnt_r[b] == '0)
                    begin
                        chopState_nxt[b] = CHOP_DRIVE;
                    end
                    else
                    begin
                        offCnt_nxt[b] = offCnt_r[b] - OFF_CNT_W'(1);
                    end
                end
            endcase
            if (!run || ocpFlag_r[b])
            begin
                gate_nxt[b] = GATE_OFF;
            end
            else if (chopState_r[b] == CHOP_OFF)
            begin
                // Mixed decay has no current history in direct mode, so every cycle splits.
                unique case (decay_r)
                    DECAY_SLOW: gate_nxt[b] = GATE_LOW;
                    DECAY_FAST: gate_nxt[b] = GATE_OFF;
                    default: gate_nxt[b] = (offCnt_r[b] >= (offLen >> 1)) ? GATE_OFF : GATE_LOW;
                endcase
            end
            else
            begin
                unique case (cmd[b])
                    CMD_COAST: gate_nxt[b] = GATE_OFF;
                    CMD_REV: gate_nxt[b] = GATE_REV;
                    CMD_FWD: gate_nxt[b] = GATE_FWD;
                    CMD_BRAKE: gate_nxt[b] = GATE_LOW;
                endcase
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            for (int b = 0; b < 2; b++)
            begin
                chopState_r[b] <= CHOP_DRIVE;
                offCnt_r[b] <= '0;
                gate_r[b] <= GATE_OFF;
            end
        end
        else
        begin
            for (int b = 0; b < 2; b++)
            begin
                chopState_r[b] <= chopState_nxt[b];
                offCnt_r[b] <= offCnt_nxt[b];
                gate_r[b] <= gate_nxt[b];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks on bridge A.
    logic driveOkA;
    assign driveOkA = run && !ocpFlag_r[0] && chopState_r[0] == CHOP_DRIVE;

    sequence tripA;
        driveOkA && isDriving(cmd[0]) && trip[0];
    endsequence

    sequence offExpireA;
        chopState_r[0] == CHOP_OFF && offCnt_r[0] == '0;
    endsequence

    direct_forward_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        driveOkA && directSel_r && bridgeAInputOne && !bridgeAInputTwo |=> gateA == GATE_FWD)
        else $error("forward input did not drive forward");

    direct_coast_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        driveOkA && directSel_r && !bridgeAInputOne && !bridgeAInputTwo |=> gateA == GATE_OFF)
        else $error("coast input did not release both outputs");

    indexer_follow_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        driveOkA && !directSel_r && indexerCmdA == CMD_BRAKE |=> gateA == GATE_LOW)
        else $error("indexer command not followed");

    chop_entry_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        tripA |=> chopState_r[0] == CHOP_OFF && offCnt_r[0] == offTotal($past(offTime_r)) - 1'b1)
        else $error("trip did not start the off time");

    off_expire_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        offExpireA |=> chopState_r[0] == CHOP_DRIVE)
        else $error("off time did not end");

    off_hold_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        chopState_r[0] == CHOP_OFF && offCnt_r[0] != '0 |=> chopState_r[0] == CHOP_OFF)
        else $error("off time ended early");

    gain_forty_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        driveOkA && isDriving(cmd[0]) && gainSel_r == 2'h3 &&
        (32'(senseMvA) * 32'd40 * 32'd256 >= 32'd2750 * 32'(torque_r))
        |=> chopState_r[0] == CHOP_OFF)
        else $error("gain of forty did not trip");

    no_trip_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        driveOkA && isDriving(cmd[0]) &&
        (32'(senseMvA) * 32'(senseGain(gainSel_r)) * 32'd256 < 32'd2750 * 32'(torque_r))
        |=> chopState_r[0] == CHOP_DRIVE)
        else $error("chopped below threshold");

    ocp_low_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        run && isDriving(cmd[0]) && ocpSel_r == 2'h0 && fetDropMvA >= 11'd250 |=> ocpFlag_r[0])
        else $error("overcurrent not flagged at 250 mV");

    mixed_tail_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        run && !ocpFlag_r[0] && chopState_r[0] == CHOP_OFF && decay_r == DECAY_MIXED &&
        offCnt_r[0] < (offLen >> 1) |=> gateA == GATE_LOW)
        else $error("mixed decay tail not slow");

endmodule

// ===== dpwmc_pkg.sv
// Constants, field layouts and types shared by the direct-input chopper.
// Assumes a single 250 MHz core clock and an APB master with 32-bit data.
// Summary of operation
// - Setting the direct-input select bit in the off-time register hands output control to the four bridge input pins.
// - In direct mode each input pair maps 00 to both outputs off, 01 to reverse, 10 to forward and 11 to both low.
// - Mixed and automatic mixed decay are applied on every chopping cycle in direct mode.
// - Current regulation stays active in direct mode, with the full-scale reference fixed at 2750 mV.
// - The torque setting still scales that reference and the selected sense gain still applies.
// - On reaching the chopping threshold a bridge is switched off for the off time and then driven again.
// - The off time is programmable in 500 ns steps from 500 ns to 128 us by the off-time field.
// - Chopping is detected by comparing the sense voltage times the amplifier gain with the reference.
// - The threshold is the reference times torque over 256 times gain times sense resistance.
// - The sense gain field selects a gain of 5, 10, 20 or 40.
// - The overcurrent field selects a transistor drop trip level of 250, 500, 750 or 1000 mV.
package dpwmc_pkg;

    // Bus and register map.
    localparam int APB_ADDR_W = 8;
    localparam logic [APB_ADDR_W-1:0] CTRL_OFFS = 8'h00;
    localparam logic [APB_ADDR_W-1:0] OFFT_OFFS = 8'h04;
    localparam logic [APB_ADDR_W-1:0] TORQ_OFFS = 8'h08;
    localparam logic [APB_ADDR_W-1:0] DECAY_OFFS = 8'h0c;
    localparam logic [APB_ADDR_W-1:0] STAT_OFFS = 8'h10;

    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_GAIN_LSB = 1;
    localparam int CTRL_OCP_LSB = 3;
    localparam int OFFT_TIME_LSB = 0;
    localparam int OFFT_DIRECT_BIT = 8;
    localparam int STAT_OCP_LSB = 0;
    localparam int STAT_CHOP_LSB = 2;
    localparam int STAT_DIRECT_BIT = 4;

    localparam logic [1:0] GAIN_RST = 2'h0;
    localparam logic [1:0] OCP_RST = 2'h0;
    localparam logic [7:0] OFFT_RST = 8'h30;
    localparam logic [7:0] TORQ_RST = 8'hff;

    // Timing.
    localparam int CLK_PERIOD_PS = 4000;
    localparam int OFF_TIME_FIELD_STEP_NS = 500;
    localparam int OFF_TIME_FIELD_STEP_CYCLES = (OFF_TIME_FIELD_STEP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int OFF_CNT_W = 16;

    // Analog quantities carried as millivolt codes.
    localparam int SENSE_W = 10;
    localparam int DROP_W = 11;
    localparam int CMP_W = 28;
    localparam int TORQUE_SHIFT = 8;
    localparam logic [11:0] VREF_FULL_MV = 12'habe;
    localparam logic [5:0] GAIN_X5 = 6'h05;
    localparam logic [5:0] GAIN_X10 = 6'h0a;
    localparam logic [5:0] GAIN_X20 = 6'h14;
    localparam logic [5:0] GAIN_X40 = 6'h28;
    localparam logic [DROP_W-1:0] OCP_MV_250 = 11'h0fa;
    localparam logic [DROP_W-1:0] OCP_MV_500 = 11'h1f4;
    localparam logic [DROP_W-1:0] OCP_MV_750 = 11'h2ee;
    localparam logic [DROP_W-1:0] OCP_MV_1000 = 11'h3e8;

    // Bridge input pair codes.
    localparam logic [1:0] CMD_COAST = 2'h0;
    localparam logic [1:0] CMD_REV = 2'h1;
    localparam logic [1:0] CMD_FWD = 2'h2;
    localparam logic [1:0] CMD_BRAKE = 2'h3;

    typedef enum logic [1:0] {
        DECAY_SLOW = 2'h0,
        DECAY_FAST = 2'h1,
        DECAY_MIXED = 2'h2,
        DECAY_AUTO = 2'h3
    } dpwmc_decay_t;

    typedef enum logic {CHOP_DRIVE, CHOP_OFF} dpwmc_chop_t;

    typedef struct packed {
        logic oneHigh;
        logic oneLow;
        logic twoHigh;
        logic twoLow;
    } dpwmc_gate_t;

    localparam dpwmc_gate_t GATE_OFF = 4'h0;
    localparam dpwmc_gate_t GATE_FWD = 4'h9;
    localparam dpwmc_gate_t GATE_REV = 4'h6;
    localparam dpwmc_gate_t GATE_LOW = 4'h5;

endpackage

// ===== dpwmc_ctrl_model.sv
// Behavioural motion controller that drives the bridge input pins and the sleep pin.
// Assumes bench requests arrive on core_clk edges; it only models the controller's timing duties.
`timescale 1ns/1ps
module dpwmc_ctrl_model #(
    parameter int ResetWaitCycles = 2500,
    parameter int WakeCycles = 250000
) (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic rst_b,
    // Requests from the bench, pin pair {one,two}.
    input wire logic [1:0] cmdA,
    input wire logic [1:0] cmdB,
    input wire logic sleepReq,
    // Pins toward the device.
    output logic bridgeAInputOne,
    output logic bridgeAInputTwo,
    output logic bridgeBInputOne,
    output logic bridgeBInputTwo,
    output logic sleepLowInput_b,
    // High once the device may be relied upon.
    output logic ctrlReady
);
    // Wide enough for the full wake time at the core clock rate.
    logic [17:0] waitCnt_r;

    ////////////////////////////////////////
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            {bridgeAInputOne, bridgeAInputTwo, bridgeBInputOne, bridgeBInputTwo} <= 4'h0;
            sleepLowInput_b <= 1'b1;
            waitCnt_r <= 18'(ResetWaitCycles);
        end
        else
        begin
            // Both pins of a pair move on one edge, so no half-changed command is ever seen.
            {bridgeAInputOne, bridgeAInputTwo, bridgeBInputOne, bridgeBInputTwo} <= {cmdA, cmdB};
            sleepLowInput_b <= !sleepReq;
            if (sleepReq)
                waitCnt_r <= 18'(WakeCycles);
            else if (waitCnt_r != 18'h0)
                waitCnt_r <= waitCnt_r - 18'h1;
        end
    end

    assign ctrlReady = (waitCnt_r == 18'h0);
endmodule

// ===== dpwmc_core_tb.sv
// Self-checking bench for the direct-input chopper core, registers reached over APB.
// Assumes the controller model owns the bridge pins; the bench owns sense, drop and indexer inputs.
`timescale 1ns/1ps
module dpwmc_core_tb;
    import dpwmc_pkg::*;
    // A short off-time step keeps the longest off time at a few hundred cycles.
    localparam int StepCyc = 2;
    logic core_clk, rst_b, psel, penable, pwrite, pready, pslverr, rdErr;
    logic [APB_ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, rdVal;
    logic pinA1, pinA2, pinB1, pinB2, sleepB, sleepReq, ctrlReady;
    logic [1:0] cmdA, cmdB, idxA, idxB;
    logic [SENSE_W-1:0] senseA, senseB;
    logic [DROP_W-1:0] dropA, dropB;
    dpwmc_gate_t gateA, gateB;
    int errCount = 0;
    int numChecks = 0;
    int gains [4] = '{5, 10, 20, 40};
    int ocpMv [4] = '{250, 500, 750, 1000};
    dpwmc_gate_t gExp [4] = '{GATE_OFF, GATE_REV, GATE_FWD, GATE_LOW};
    logic [7:0] regAddr [5] = '{CTRL_OFFS, OFFT_OFFS, TORQ_OFFS, DECAY_OFFS, STAT_OFFS};
    logic [31:0] regRst [5] = '{32'h0, 32'(OFFT_RST), 32'(TORQ_RST), 32'h0, 32'h0};

    dpwmc_core #(.OffStepCycles(StepCyc)) i_dpwmc_core (
        .core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .bridgeAInputOne(pinA1), .bridgeAInputTwo(pinA2), .bridgeBInputOne(pinB1),
        .bridgeBInputTwo(pinB2), .indexerCmdA(idxA), .indexerCmdB(idxB),
        .sleepLowInput_b(sleepB), .senseMvA(senseA), .senseMvB(senseB),
        .fetDropMvA(dropA), .fetDropMvB(dropB), .gateA(gateA), .gateB(gateB));

    // The wake wait is cut short so the run stays brief.
    dpwmc_ctrl_model #(.WakeCycles(250)) i_dpwmc_ctrl_model (
        .core_clk(core_clk), .rst_b(rst_b), .cmdA(cmdA), .cmdB(cmdB), .sleepReq(sleepReq),
        .bridgeAInputOne(pinA1), .bridgeAInputTwo(pinA2), .bridgeBInputOne(pinB1),
        .bridgeBInputTwo(pinB2), .sleepLowInput_b(sleepB), .ctrlReady(ctrlReady));

    ////////////////////////////////////////
    task automatic stop_test();
        if (errCount == 0 && numChecks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        numChecks++;
        if (seen !== exp)
        begin
            errCount++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic timeout();
        errCount++;
        $display("[ERR] wait expected done seen timeout");
        stop_test();
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    // One APB transfer; the answer is taken only at the edge where pready is seen.
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
        int n = 0;
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wdata;
        @(posedge core_clk);
        penable <= 1'b1;
        do
        begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1)
            timeout();
        rdVal = prdata;
        rdErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wait_ready();
        int n = 0;
        while (ctrlReady !== 1'b1 && n < 3000)
        begin
            @(posedge core_clk);
            n++;
        end
        if (ctrlReady !== 1'b1)
            timeout();
        settle(1);
    endtask

    // Raises sense on bridge A until a trip, then counts off-time gate cycles by kind.
    task automatic chop(input logic [SENSE_W-1:0] lvl, output int nOff, output int nLow);
        int n = 0;
        nOff = 0;
        nLow = 0;
        while (n < 600)
        begin
            @(posedge core_clk);
            senseA <= (nOff + nLow == 0) ? lvl : '0;
            #1;
            n++;
            if (gateA === GATE_OFF)
                nOff++;
            else if (gateA === GATE_LOW)
                nLow++;
            else if (nOff + nLow > 0 || n > 12)
                break;
        end
    endtask

    function automatic int exp_off(input int d, input int tot);
        return (d == 1) ? tot : (d >= 2) ? tot - tot / 2 : 0;
    endfunction

    ////////////////////////////////////////
    initial
    begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    initial
    begin
        int nOff;
        int nLow;
        int tot;
        int thr;
        rst_b = 1'b0;
        {psel, penable, pwrite, sleepReq, rdErr, paddr, pwdata, rdVal} = '0;
        {cmdA, cmdB, idxA, idxB, senseA, senseB, dropA, dropB} = '0;
        repeat (16) @(posedge core_clk);
        rst_b <= 1'b1;
        wait_ready();
        for (int i = 0; i < 5; i++)
        begin
            apb(1'b0, regAddr[i], '0);
            check("reset value", rdVal, regRst[i]);
        end
        apb(1'b0, 8'h14, '0);
        check("unmapped error", 32'(rdErr), 32'h1);
        check("unmapped data", rdVal, 32'h0);
        apb(1'b1, TORQ_OFFS, 32'h80);
        apb(1'b1, CTRL_OFFS, 32'h1);
        for (int m = 0; m < 2; m++)
        begin
            apb(1'b1, OFFT_OFFS, m << OFFT_DIRECT_BIT);
            for (int k = 0; k < 4; k++)
            begin
                @(posedge core_clk);
                cmdA <= (m == 1) ? 2'(k) : 2'(~k);
                idxA <= (m == 1) ? 2'(~k) : 2'(k);
                cmdB <= (m == 1) ? 2'(3 - k) : 2'(k);
                idxB <= (m == 1) ? 2'(k) : 2'(3 - k);
                settle(4);
                check("bridge A gate", 32'(gateA), 32'(gExp[k]));
                check("bridge B gate", 32'(gateB), 32'(gExp[3 - k]));
            end
            apb(1'b0, STAT_OFFS, '0);
            check("select echo", rdVal, m << STAT_DIRECT_BIT);
        end
        @(posedge core_clk);
        cmdA <= CMD_FWD;
        sleepReq <= 1'b1;
        settle(4);
        check("sleep gate", 32'(gateA), 32'(GATE_OFF));
        @(posedge core_clk);
        sleepReq <= 1'b0;
        wait_ready();
        check("wake gate", 32'(gateA), 32'(GATE_FWD));
        for (int g = 0; g < 4; g++)
        begin
            apb(1'b1, CTRL_OFFS, 1 | (g << CTRL_GAIN_LSB));
            thr = (2750 * 128 + 256 * gains[g] - 1) / (256 * gains[g]);
            chop(SENSE_W'(thr - 1), nOff, nLow);
            check("below threshold", 32'(nOff + nLow), 32'h0);
            chop(SENSE_W'(thr), nOff, nLow);
            check("shortest off time", 32'(nLow), 32'(StepCyc));
        end
        apb(1'b1, OFFT_OFFS, 32'h103);
        tot = 4 * StepCyc;
        for (int d = 0; d < 4; d++)
        begin
            apb(1'b1, DECAY_OFFS, d);
            repeat (2)
            begin
                chop(10'd300, nOff, nLow);
                check("fast part", 32'(nOff), 32'(exp_off(d, tot)));
                check("slow part", 32'(nLow), 32'(tot - exp_off(d, tot)));
            end
        end
        @(posedge core_clk);
        cmdB <= CMD_FWD;
        senseB <= 10'd300;
        settle(3);
        apb(1'b0, STAT_OFFS, '0);
        check("bridge B off", rdVal, 32'h18);
        @(posedge core_clk);
        senseB <= '0;
        cmdB <= CMD_COAST;
        apb(1'b1, OFFT_OFFS, 32'h1ff);
        apb(1'b1, DECAY_OFFS, 32'h0);
        chop(10'd300, nOff, nLow);
        check("longest off time", 32'(nLow), 32'(256 * StepCyc));
        for (int o = 0; o < 4; o++)
        begin
            apb(1'b1, CTRL_OFFS, 1 | (o << CTRL_OCP_LSB));
            @(posedge core_clk);
            dropA <= DROP_W'(ocpMv[o] - 1);
            settle(4);
            check("below trip", 32'(gateA), 32'(GATE_FWD));
            @(posedge core_clk);
            dropA <= DROP_W'(ocpMv[o]);
            settle(4);
            check("trip gate", 32'(gateA), 32'(GATE_OFF));
            apb(1'b0, STAT_OFFS, '0);
            check("trip flag", rdVal, 32'h11);
            @(posedge core_clk);
            dropA <= '0;
            apb(1'b1, STAT_OFFS, 32'h1);
            apb(1'b0, STAT_OFFS, '0);
            check("trip cleared", rdVal, 32'h10);
        end
        stop_test();
    end
endmodule
